// file: src/pltc_params.svh
`ifndef PLTC_PARAMS_SVH
`define PLTC_PARAMS_SVH

// register byte addresses on the host register port
`define PLTC_ADDR_W 14
`define PLTC_LINE_SPAN_ADDR 14'h3ff0
`define PLTC_LOCK_SHIFTS_ADDR 14'h3ff5
`define PLTC_CAPT_SHIFTS_ADDR 14'h3ff6

// reset values
`define PLTC_LINE_SPAN_RST 7'h20
`define PLTC_LOCK_SHIFTS_RST 8'h10
`define PLTC_CAPT_SHIFTS_RST 8'h42
`define PLTC_INIT_DIV 16'h0400

// field positions inside a shift register: proportional low, integral high
`define PLTC_PROP_LSB 0
`define PLTC_INTEG_LSB 4
`define PLTC_SHIFT_W 3
`define PLTC_SPAN_MSB 6
`define PLTC_SPAN_LSB 1

// loop arithmetic
`define PLTC_DIV_W 16
`define PLTC_FRAC 8
`define PLTC_ERR_W 21
`define PLTC_CYC_W 20
`define PLTC_WORK_W 40
`define PLTC_GAIN_MUL 3
`define PLTC_PROP_BIAS 11
`define PLTC_INTEG_BIAS 19
`define PLTC_PIX_PER_UNIT 12
`define PLTC_DIV_MIN 16'h0200

// lock detection
`define PLTC_LOCK_LINES 4
`define PLTC_LOCK_THRESH 8
`define PLTC_LCNT_W 4

`endif

// file: src/pltc_pkg.sv
`include "pltc_params.svh"

package pltc_pkg;

  typedef enum logic {PLTC_CAPTURE, PLTC_LOCKED} pltc_mode_t;

  typedef struct packed {
    pltc_mode_t mode;
    logic [`PLTC_LCNT_W-1:0] cnt;
  } pltc_det_state_t;

  typedef struct packed {
    logic [6:0] line_span;
    logic [7:0] lock_shifts;
    logic [7:0] capt_shifts;
    logic [7:0] rdata;
    logic hs_d;
    logic seen;
    logic [`PLTC_CYC_W-1:0] cyc;
    logic signed [`PLTC_ERR_W-1:0] err;
    logic err_vld;
    logic upd;
    logic signed [`PLTC_WORK_W-1:0] integ;
    logic [`PLTC_DIV_W-1:0] div;
    logic [`PLTC_DIV_W:0] acc;
    logic pix_tick;
    logic locked;
  } pltc_loop_state_t;

endpackage : pltc_pkg

// file: src/pltc_lock_det.sv
`timescale 1ns/1ps
`include "pltc_params.svh"

module pltc_lock_det
  import pltc_pkg::*;
#(
  parameter int unsigned LOCK_LINES = `PLTC_LOCK_LINES,
  parameter int unsigned LOCK_THRESH = `PLTC_LOCK_THRESH
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // per-line phase error
  input wire logic err_vld_i,
  input wire logic signed [`PLTC_ERR_W-1:0] err_i,
  // lock state
  output logic locked_o
);

  ////////////////////////////////////////////////////////////////////////////
  generate
    if (LOCK_LINES < 1 || LOCK_LINES >= (1 << `PLTC_LCNT_W) || LOCK_THRESH < 1)
    begin : g_bad
      $error("pltc_lock_det: lock line count or threshold out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  pltc_det_state_t q;
  pltc_det_state_t nx;
  logic [`PLTC_ERR_W-1:0] mag;
  logic below;

  always_comb
  begin
    nx = q;
    mag = err_i[`PLTC_ERR_W-1] ? (~err_i + 1'b1) : err_i;
    below = (mag < `PLTC_ERR_W'(LOCK_THRESH));
    if (err_vld_i)
    begin
      case (q.mode)
        PLTC_CAPTURE:
        begin
          if (!below)
          begin
            nx.cnt = '0;
          end
          else if (q.cnt >= `PLTC_LCNT_W'(LOCK_LINES - 1))
          begin
            nx.mode = PLTC_LOCKED;
            nx.cnt = '0;
          end
          else
          begin
            nx.cnt = q.cnt + 1'b1;
          end
        end
        PLTC_LOCKED:
        begin
          if (!below)
          begin
            nx.mode = PLTC_CAPTURE;
            nx.cnt = '0;
          end
        end
        default:
        begin
          nx.mode = PLTC_CAPTURE;
          nx.cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q <= '{mode: PLTC_CAPTURE, cnt: '0};
    end
    else
    begin
      q <= nx;
    end
  end

  assign locked_o = (q.mode == PLTC_LOCKED);

endmodule : pltc_lock_det

// file: src/pltc_loop.sv
// Notes on behaviour
// - locked: ratio from locking shift pair
// - lock after 4 consecutive lines below threshold
// - error at or above threshold: capture, capture pair
// - gains 3*span*2^(A-11) and 3*span*2^(B-19)
// - larger shifts give larger gains, faster capture
// - line span register 7 bits, bit 0 ignored
// - line holds 12*(2*span+1) pixels
`timescale 1ns/1ps
`include "pltc_params.svh"

module pltc_loop
  import pltc_pkg::*;
#(
  parameter int unsigned LOCK_LINES = `PLTC_LOCK_LINES,
  parameter int unsigned LOCK_THRESH = `PLTC_LOCK_THRESH,
  parameter logic [`PLTC_DIV_W-1:0] INIT_DIV = `PLTC_INIT_DIV
)
(
  // clock and reset (clock is the multiplied high-frequency clock)
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // horizontal sync, synchronous to sys_clk_i
  input wire logic hsync_i,
  // host register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`PLTC_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // pixel clock and loop state
  output logic pix_tick_o,
  output logic [`PLTC_DIV_W-1:0] divider_ratio_o,
  output logic signed [`PLTC_ERR_W-1:0] phs_error_o,
  output logic locked_o
);

  ////////////////////////////////////////////////////////////////////////////
  generate
    if (INIT_DIV < `PLTC_DIV_MIN)
    begin : g_bad_div
      $error("pltc_loop: initial divider below the allowed minimum");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  pltc_loop_state_t q;
  pltc_loop_state_t nx;
  logic det_locked;

  pltc_lock_det #(
    .LOCK_LINES(LOCK_LINES),
    .LOCK_THRESH(LOCK_THRESH)
  ) u_lock_det (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .err_vld_i(q.err_vld),
    .err_i(q.err),
    .locked_o(det_locked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // loop arithmetic
  logic [5:0] span;
  logic [10:0] pix_per_line;
  logic [26:0] expect_full;
  logic signed [`PLTC_ERR_W-1:0] err_now;
  logic [`PLTC_SHIFT_W-1:0] prop_sh;
  logic [`PLTC_SHIFT_W-1:0] integ_sh;
  logic [7:0] shifts;
  logic signed [`PLTC_WORK_W-1:0] gain_base;
  logic signed [`PLTC_WORK_W-1:0] prop_term;
  logic signed [`PLTC_WORK_W-1:0] integ_next;
  logic signed [`PLTC_WORK_W-1:0] div_sum;
  logic [`PLTC_DIV_W:0] acc_inc;
  logic line_start;

  always_comb
  begin
    nx = q;
    nx.pix_tick = 1'b0;
    nx.err_vld = 1'b0;
    nx.upd = 1'b0;
    nx.locked = det_locked;

    // register writes and reads
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `PLTC_LINE_SPAN_ADDR: nx.line_span = reg_wdata_i[6:0];
        `PLTC_LOCK_SHIFTS_ADDR: nx.lock_shifts = reg_wdata_i;
        `PLTC_CAPT_SHIFTS_ADDR: nx.capt_shifts = reg_wdata_i;
        default: nx.line_span = q.line_span;
      endcase
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `PLTC_LINE_SPAN_ADDR: nx.rdata = {1'b0, q.line_span};
        `PLTC_LOCK_SHIFTS_ADDR: nx.rdata = q.lock_shifts;
        `PLTC_CAPT_SHIFTS_ADDR: nx.rdata = q.capt_shifts;
        default: nx.rdata = 8'h00;
      endcase
    end

    // only the upper six bits of the span take part in any calculation
    span = q.line_span[`PLTC_SPAN_MSB:`PLTC_SPAN_LSB];
    pix_per_line = 11'(`PLTC_PIX_PER_UNIT * (2 * span + 1));

    // error: measured line length against pixels*divider, in fast cycles
    expect_full = 27'(pix_per_line * q.div);
    err_now = `PLTC_ERR_W'($signed({1'b0, q.cyc}) -
      $signed({2'b00, expect_full[26:`PLTC_FRAC]}));

    nx.hs_d = hsync_i;
    line_start = hsync_i & ~q.hs_d;
    if (line_start)
    begin
      nx.cyc = `PLTC_CYC_W'(1);
      nx.seen = 1'b1;
      // first edge after reset has no full line behind it
      if (q.seen)
      begin
        nx.err = err_now;
        nx.err_vld = 1'b1;
      end
    end
    else if (q.cyc != '1)
    begin
      nx.cyc = q.cyc + 1'b1;
    end

    // the detector settles on err_vld; the update runs one cycle later
    // so the pair chosen already reflects this line's error
    nx.upd = q.err_vld;
    shifts = det_locked ? q.lock_shifts : q.capt_shifts;
    prop_sh = shifts[`PLTC_PROP_LSB +: `PLTC_SHIFT_W];
    integ_sh = shifts[`PLTC_INTEG_LSB +: `PLTC_SHIFT_W];

    gain_base = `PLTC_WORK_W'(q.err * $signed({1'b0, span}) * `PLTC_GAIN_MUL);
    // larger shift means larger gain, hence faster capture
    prop_term = (gain_base <<< prop_sh) >>> (`PLTC_PROP_BIAS - `PLTC_FRAC);
    integ_next = q.integ + ((gain_base <<< integ_sh) >>> (`PLTC_INTEG_BIAS - `PLTC_FRAC));
    div_sum = integ_next + prop_term;

    if (q.upd)
    begin
      // integrator clamped too, to stop wind-up while the ratio is pinned
      if (integ_next < $signed({24'h0000_00, `PLTC_DIV_MIN}))
      begin
        nx.integ = $signed({24'h0000_00, `PLTC_DIV_MIN});
      end
      else if (integ_next > $signed({24'h0000_00, 16'hffff}))
      begin
        nx.integ = $signed({24'h0000_00, 16'hffff});
      end
      else
      begin
        nx.integ = integ_next;
      end
      if (div_sum < $signed({24'h0000_00, `PLTC_DIV_MIN}))
      begin
        nx.div = `PLTC_DIV_MIN;
      end
      else if (div_sum > $signed({24'h0000_00, 16'hffff}))
      begin
        nx.div = 16'hffff;
      end
      else
      begin
        nx.div = div_sum[`PLTC_DIV_W-1:0];
      end
    end

    // fractional divider: one pixel tick every div/2^frac fast cycles
    // a falling ratio can leave the accumulator above it; the idle cycle
    // after each tick keeps the tick a one-cycle pulse while it drains
    acc_inc = q.acc + (17'(1) << `PLTC_FRAC);
    if (acc_inc >= {1'b0, q.div} && !q.pix_tick)
    begin
      nx.acc = acc_inc - {1'b0, q.div};
      nx.pix_tick = 1'b1;
    end
    else
    begin
      nx.acc = acc_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q.line_span <= `PLTC_LINE_SPAN_RST;
      q.lock_shifts <= `PLTC_LOCK_SHIFTS_RST;
      q.capt_shifts <= `PLTC_CAPT_SHIFTS_RST;
      q.rdata <= 8'h00;
      q.hs_d <= 1'b0;
      q.seen <= 1'b0;
      q.cyc <= '0;
      q.err <= '0;
      q.err_vld <= 1'b0;
      q.upd <= 1'b0;
      q.integ <= $signed({24'h0000_00, INIT_DIV});
      q.div <= INIT_DIV;
      q.acc <= '0;
      q.pix_tick <= 1'b0;
      q.locked <= 1'b0;
    end
    else
    begin
      q <= nx;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign pix_tick_o = q.pix_tick;
  assign divider_ratio_o = q.div;
  assign phs_error_o = q.err;
  assign locked_o = q.locked;

endmodule : pltc_loop

// file: verification/pltc_loop_monitor.sv
`timescale 1ns/1ps
`include "pltc_params.svh"
module pltc_loop_monitor
  import pltc_pkg::*;
#(
  parameter int LOCK_THRESH = `PLTC_LOCK_THRESH
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // inputs
  input wire logic hsync_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`PLTC_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  // outputs
  input wire logic [7:0] reg_rdata_o,
  input wire logic pix_tick_o,
  input wire logic [`PLTC_DIV_W-1:0] divider_ratio_o,
  input wire logic signed [`PLTC_ERR_W-1:0] phs_error_o,
  input wire logic locked_o
);
  logic big;
  logic hit;
  // signed compare: a short line gives a negative error
  assign big = (phs_error_o >= LOCK_THRESH) || (phs_error_o <= -LOCK_THRESH);
  assign hit = reg_addr_i inside {`PLTC_LINE_SPAN_ADDR, `PLTC_LOCK_SHIFTS_ADDR, `PLTC_CAPT_SHIFTS_ADDR};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  chk_err_edge: assert property ($changed(phs_error_o) |-> $past(hsync_i) && !$past(hsync_i, 2))
    else $error("error moved off a line edge");
  chk_div_edge: assert property ($changed(divider_ratio_o) |-> $past(hsync_i, 3) && !$past(hsync_i, 4))
    else $error("ratio moved off a line edge");
  chk_lock_edge: assert property ($changed(locked_o) |-> $past(hsync_i, 3) && !$past(hsync_i, 4))
    else $error("lock moved off a line edge");
  chk_lock_small: assert property ($rose(locked_o) |-> !big)
    else $error("locked on a large error");
  chk_unlock_big: assert property (hsync_i && !$past(hsync_i) ##1 big |-> ##2 !locked_o)
    else $error("still locked after a large error");
  chk_span_bit7: assert property (reg_rd_i && reg_addr_i == `PLTC_LINE_SPAN_ADDR |=> !reg_rdata_o[7])
    else $error("line span bit 7 read high");
  chk_unmapped_zero: assert property (reg_rd_i && !hit |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  chk_tick_pulse: assert property (pix_tick_o |=> !pix_tick_o)
    else $error("tick wider than one cycle");
  cover property ($rose(locked_o));
  cover property ($fell(locked_o));
  cover property (reg_wr_i ##1 reg_rd_i);
endmodule : pltc_loop_monitor
bind pltc_loop pltc_loop_monitor #(.LOCK_THRESH(LOCK_THRESH)) pltc_loop_monitor_i (.sys_clk_i, .rst_i,
  .hsync_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .pix_tick_o, .divider_ratio_o,
  .phs_error_o, .locked_o);

// file: verification/pltc_hsync_src.sv
`timescale 1ns/1ps
module pltc_hsync_src
(
  // clock
  input wire logic sys_clk_i,
  // sync out
  output logic hsync_o
);
  initial hsync_o = 1'b0;
  // edge plus five cycles: line outputs have settled on return
  task automatic edge_out();
    @(posedge sys_clk_i);
    hsync_o <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    hsync_o <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask : edge_out
  task automatic gap(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : gap
endmodule : pltc_hsync_src

// file: verification/pltc_loop_tb_top.sv
`timescale 1ns/1ps
`include "pltc_params.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module pltc_loop_tb_top
  import pltc_pkg::*;
;
  localparam int TH = 8;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsync_i;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [`PLTC_ADDR_W-1:0] reg_addr_i = '0;
  logic [7:0] reg_wdata_i = '0;
  logic [7:0] reg_rdata_o;
  logic pix_tick_o;
  logic [`PLTC_DIV_W-1:0] divider_ratio_o;
  logic signed [`PLTC_ERR_W-1:0] phs_error_o;
  logic locked_o;
  int error_cnt = 0;
  int samples_checked = 0;
  longint integ = `PLTC_INIT_DIV;
  logic [15:0] div_x = `PLTC_INIT_DIV;
  int tick_cnt = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    if (pix_tick_o === 1'b1)
      tick_cnt <= tick_cnt + 1;
  end
  pltc_loop #(.LOCK_THRESH(TH)) pltc_loop_i (.sys_clk_i, .rst_i, .hsync_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .pix_tick_o, .divider_ratio_o, .phs_error_o, .locked_o);
  pltc_hsync_src pltc_hsync_src_i (.sys_clk_i, .hsync_o(hsync_i));
  ////////////////////////////////////////
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [13:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    #1 `CHK(reg_rdata_o, e)
  endtask : rd
  // ratio and integrator are both pinned to the legal divider range
  function automatic longint clampv(input longint v);
    if (v < longint'(`PLTC_DIV_MIN))
      return longint'(`PLTC_DIV_MIN);
    if (v > longint'(16'hffff))
      return longint'(16'hffff);
    return v;
  endfunction : clampv
  // one line of 12*(2*16+1) pixels plus e cycles; span stays 16 as bit 0 is ignored
  task automatic line(input int e, input int a, input int b);
    longint g;
    longint nint;
    g = e * 48;
    pltc_hsync_src_i.gap((396 * div_x) / 256 + e - 6);
    pltc_hsync_src_i.edge_out();
    nint = integ + ((g <<< b) >>> 11);
    div_x = 16'(clampv(nint + ((g <<< a) >>> 3)));
    integ = clampv(nint);
    `CHK(phs_error_o, 21'(e))
    `CHK(divider_ratio_o, div_x)
  endtask : line
  task automatic t_regs();
    rd(`PLTC_LINE_SPAN_ADDR, 8'h20);
    rd(`PLTC_LOCK_SHIFTS_ADDR, 8'h10);
    rd(`PLTC_CAPT_SHIFTS_ADDR, 8'h42);
    wr(`PLTC_LINE_SPAN_ADDR, 8'ha1);
    rd(`PLTC_LINE_SPAN_ADDR, 8'h21);
    rd(14'h3ff1, 8'h00);
    // capture 3/4: gap under 3, legal at span 16, not the 2/4 pair
    wr(`PLTC_CAPT_SHIFTS_ADDR, 8'h43);
    wr(`PLTC_LOCK_SHIFTS_ADDR, 8'h10);
    rd(`PLTC_CAPT_SHIFTS_ADDR, 8'h43);
    $display("test regs done");
  endtask : t_regs
  task automatic t_lock();
    int t0;
    pltc_hsync_src_i.edge_out();
    for (int i = 1; i <= 4; i++)
    begin
      t0 = tick_cnt;
      line(0, 0, 1);
      `CHK(locked_o, 1'(i == 4))
      `CHK(tick_cnt - t0, 396)
    end
    line(TH - 1, 0, 1);
    `CHK(locked_o, 1'b1)
    $display("test lock done");
  endtask : t_lock
  task automatic t_capture();
    logic [15:0] d0;
    d0 = divider_ratio_o;
    line(TH, 3, 4);
    `CHK(locked_o, 1'b0)
    // the locking pair would move the ratio by 16'h0030 only
    `CHK(divider_ratio_o - d0 > 16'h0030, 1'b1)
    line(-20, 3, 4);
    `CHK(locked_o, 1'b0)
    $display("test capture done");
  endtask : t_capture
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_lock();
    t_capture();
    finish_test();
  end
  // about 12k cycles of lines; four times that is a hang
  initial
  begin
    #200000;
    error_cnt++;
    finish_test();
  end
endmodule : pltc_loop_tb_top
